// >>> cct_capture_edge.sv
// Capture input edge detector with arming during halt.
// Assumes the pin is synchronous; wake pulses on the halt exit cycle.
`timescale 1ns/1ps
module cct_capture_edge (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic pin,
   input  wire logic rising,
   input  wire logic halt,
   input  wire logic wake,
   output logic      hit
);
   logic prev;
   logic armed;
   logic edge_seen;

   assign edge_seen = rising ? (pin & !prev) : (!pin & prev);

   // Pin history and halt arming
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prev  <= 1'b0;
         armed <= 1'b0;
      end else begin
         prev <= pin;
         if (halt && edge_seen) begin
            armed <= 1'b1;
         end else if (wake) begin
            armed <= 1'b0;
         end
      end
   end

   // Live edge, or the armed edge replayed at halt exit
   assign hit = !halt && (edge_seen || (wake && armed));

   armed_replay_a: assert property (@(posedge clock) disable iff (!rst_b)
      (armed && wake) |-> hit)
      else $error("armed capture lost at halt exit");
endmodule

// >>> cct_pins.sv
// Far-side pin model: capture inputs and external clock source.
// Assumes the bench sets levels; the clock pin stands still unless run.
`timescale 1ns/1ps
module cct_pins (
   input  wire logic       clk,
   input  wire logic [1:0] lvl,
   input  wire logic       run,
   output logic            cap_one,
   output logic            cap_two,
   output logic            ext_clk
);
   // Pins move just after the edge; clock toggles only while run
   always @(posedge clk) begin
      cap_one <= lvl[0];
      cap_two <= lvl[1];
      if (run) ext_clk <= ~ext_clk;
   end
   initial {cap_one, cap_two, ext_clk} = 3'h0;
endmodule

// >>> cct_pkg.sv
// Shared constants for the capture/compare timer: register offsets,
// bit positions, reset values and clock-select encoding.
// Assumes a byte-wide register port addressed by the printed offsets.
package cct_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [7:0] OFS_CTRL_TWO = 8'h1A;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h1B;
   localparam logic [7:0] OFS_STATUS   = 8'h1C;
   localparam logic [7:0] OFS_CAP1_HI  = 8'h1D;
   localparam logic [7:0] OFS_CAP1_LO  = 8'h1E;
   localparam logic [7:0] OFS_CMP1_HI  = 8'h1F;
   localparam logic [7:0] OFS_CMP1_LO  = 8'h20;
   localparam logic [7:0] OFS_CNT_HI   = 8'h21;
   localparam logic [7:0] OFS_CNT_LO   = 8'h22;
   localparam logic [7:0] OFS_ALT_HI   = 8'h23;
   localparam logic [7:0] OFS_ALT_LO   = 8'h24;
   localparam logic [7:0] OFS_CAP2_HI  = 8'h25;
   localparam logic [7:0] OFS_CAP2_LO  = 8'h26;
   localparam logic [7:0] OFS_CMP2_HI  = 8'h27;
   localparam logic [7:0] OFS_CMP2_LO  = 8'h28;

   // Control one bits
   localparam int B_CAP_IE = 7;
   localparam int B_CMP_IE = 6;
   localparam int B_OVF_IE = 5;
   localparam int B_FORCE2 = 4;
   localparam int B_FORCE1 = 3;
   localparam int B_LVL2   = 2;
   localparam int B_EDGE1  = 1;
   localparam int B_LVL1   = 0;
   // Control two bits
   localparam int B_PIN1_EN  = 7;
   localparam int B_PIN2_EN  = 6;
   localparam int B_SINGLE   = 5;
   localparam int B_PWM      = 4;
   localparam int B_CLK_LSB  = 2;
   localparam int B_EDGE2    = 1;
   localparam int B_EXT_EDGE = 0;
   // Status bits; flag vector index k sits at status bit k+3
   localparam int B_DIS  = 2;
   localparam int F_CAP1 = 4;
   localparam int F_CMP1 = 3;
   localparam int F_OVF  = 2;
   localparam int F_CAP2 = 1;
   localparam int F_CMP2 = 0;

   // Reset values and counter limits
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [7:0]  CMP_HI_RESET  = 8'h80;
   localparam logic [7:0]  CMP_LO_RESET  = 8'h00;
   localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
   localparam logic [15:0] COUNTER_TOP   = 16'hFFFF;

   // Prescaler terminal counts for divide by 2, 4 and 8
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV4_LAST = 3'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   typedef enum logic [1:0] {CLK_DIV4, CLK_DIV2, CLK_DIV8, CLK_EXT} cct_clk_t;
endpackage

// >>> cct_tick_gen.sv
// Counter tick source: CPU clock prescaler or external clock edges.
// Assumes the external pin is already synchronous to the clock.
`timescale 1ns/1ps
module cct_tick_gen #(
   parameter bit HAS_EXT_CLOCK = 1'b1
) (
   input  wire logic clock,
   input  wire logic rst_b,
   cct_tick_if.gen   tk
);
   import cct_pkg::*;

   logic [2:0] div_count;
   logic [2:0] div_last;
   logic       ext_prev;
   logic       ext_hit;

   // Terminal count per selected divider
   always_comb begin
      case (tk.clock_select)
         CLK_DIV2: div_last = DIV2_LAST;
         CLK_DIV8: div_last = DIV8_LAST;
         default:  div_last = DIV4_LAST;
      endcase
   end

   // Prescaler, held while frozen
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         div_count <= 3'h0;
      end else if (!tk.freeze) begin
         div_count <= (div_count >= div_last) ? 3'h0 : div_count + 3'h1;
      end
   end

   // External pin history for edge detection
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= tk.ext_pin;
      end
   end

   assign ext_hit = tk.ext_edge ? (tk.ext_pin & !ext_prev) : (!tk.ext_pin & ext_prev);

   // One tick per divider period or per chosen external edge
   always_comb begin
      if (tk.freeze) begin
         tk.tick = 1'b0;
      end else if (tk.clock_select == CLK_EXT) begin
         tk.tick = HAS_EXT_CLOCK & ext_hit;
      end else begin
         tk.tick = (div_count >= div_last);
      end
   end

   no_ext_tick_a: assert property (@(posedge clock) disable iff (!rst_b)
      (!HAS_EXT_CLOCK && tk.clock_select == CLK_EXT) |-> !tk.tick)
      else $error("tick without an external clock pin");
   div2_rate_a: assert property (@(posedge clock) disable iff (!rst_b)
      (tk.tick && tk.clock_select == CLK_DIV2 && $stable(tk.clock_select)) |=> !tk.tick)
      else $error("divide-by-2 ticks back to back");
endmodule

// >>> cct_tick_if.sv
// Carrier between the timer core and its tick generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cct_tick_if;
   cct_pkg::cct_clk_t clock_select;
   logic              ext_edge;
   logic              freeze;
   logic              ext_pin;
   logic              tick;

   modport gen  (input clock_select, ext_edge, freeze, ext_pin, output tick);
   modport user (output clock_select, ext_edge, freeze, ext_pin, input tick);
endinterface

// >>> cct_timer.sv
// 16-bit capture/compare timer core with byte register port,
// two capture inputs, two compare pins and one interrupt line.
// Assumes all inputs are synchronous to CLOCK; pads resolve pin enables.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module cct_timer #(
   parameter bit HAS_EXT_CLOCK = 1'b1
) (
   input  wire logic                      CLOCK,
   input  wire logic                      RST_B,
   input  wire logic [cct_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [cct_pkg::DATA_W-1:0] WDATA,
   input  wire logic                      WR,
   input  wire logic                      RD,
   output logic      [cct_pkg::DATA_W-1:0] RDATA,
   input  wire logic                      CAPTURE_PIN_ONE,
   input  wire logic                      CAPTURE_PIN_TWO,
   input  wire logic                      EXT_CLOCK_PIN,
   input  wire logic                      HALT,
   input  wire logic                      GLOBAL_MASK,
   output logic                           COMPARE_PIN_ONE,
   output logic                           COMPARE_PIN_ONE_OE,
   output logic                           COMPARE_PIN_TWO,
   output logic                           COMPARE_PIN_TWO_OE,
   output logic                           IRQ
);
   import cct_pkg::*;

   // Registers and state
   logic [7:0]  ctrl_one;
   logic [7:0]  ctrl_two;
   logic        timer_disable;
   logic [15:0] counter;
   logic [15:0] capture_value_one;
   logic [15:0] capture_value_two;
   logic [15:0] cmp_value [2];
   logic [15:0] cmp_shadow [2];
   logic [7:0]  cmp_high_hold [2];
   logic [4:0]  flag;
   logic [4:0]  status_seen;
   logic        tick_d;
   logic        halt_d;

   // Combinational helpers
   logic [4:0]  flag_set;
   logic [4:0]  flag_clr;
   logic [4:0]  low_access;
   logic [1:0]  match;
   logic [1:0]  cap_hit;
   logic [15:0] target [2];
   logic        pwm_mode;
   logic        one_pulse;
   logic        div2_sel;
   logic        wake;
   logic        opm_trig;
   logic        pwm_period;
   logic        cnt_reset_wr;
   logic        counter_reload;
   logic        rd_status;
   logic        wr_ctrl_one;
   logic        irq_cause;
   logic [7:0]  next_rdata;

   cct_tick_if tk ();

   // Mode decode; PWM wins over single pulse
   assign pwm_mode  = ctrl_two[B_PWM];
   assign one_pulse = ctrl_two[B_SINGLE] & !ctrl_two[B_PWM];
   assign div2_sel  = (tk.clock_select == CLK_DIV2);
   assign wake      = halt_d & !HALT;

   // Tick generator hookup; wait is not a freeze condition
   assign tk.clock_select = cct_clk_t'(ctrl_two[B_CLK_LSB +: 2]);
   assign tk.ext_edge     = ctrl_two[B_EXT_EDGE];
   assign tk.freeze       = timer_disable | HALT;
   assign tk.ext_pin      = EXT_CLOCK_PIN;

   cct_tick_gen #(
      .HAS_EXT_CLOCK (HAS_EXT_CLOCK)
   ) u_tick (
      .clock (CLOCK),
      .rst_b (RST_B),
      .tk    (tk)
   );

   // Capture edge detectors
   cct_capture_edge u_cap_one (
      .clock  (CLOCK),
      .rst_b  (RST_B),
      .pin    (CAPTURE_PIN_ONE),
      .rising (ctrl_one[B_EDGE1]),
      .halt   (HALT),
      .wake   (wake),
      .hit    (cap_hit[0])
   );

   cct_capture_edge u_cap_two (
      .clock  (CLOCK),
      .rst_b  (RST_B),
      .pin    (CAPTURE_PIN_TWO),
      .rising (ctrl_two[B_EDGE2]),
      .halt   (HALT),
      .wake   (wake),
      .hit    (cap_hit[1])
   );

   // Register port access strobes
   assign rd_status    = RD && (ADDR == OFS_STATUS);
   assign wr_ctrl_one  = WR && (ADDR == OFS_CTRL_ONE);
   assign cnt_reset_wr = WR && ((ADDR == OFS_CNT_LO) || (ADDR == OFS_ALT_LO));
   assign low_access[F_CAP1] = (RD || WR) && (ADDR == OFS_CAP1_LO);
   assign low_access[F_CMP1] = (RD || WR) && (ADDR == OFS_CMP1_LO);
   assign low_access[F_OVF]  = (RD || WR) && (ADDR == OFS_CNT_LO);
   assign low_access[F_CAP2] = (RD || WR) && (ADDR == OFS_CAP2_LO);
   assign low_access[F_CMP2] = (RD || WR) && (ADDR == OFS_CMP2_LO);

   // Compare channels: locked buffer, PWM shadow, match detect
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      localparam logic [7:0] OFS_HI = (i == 0) ? OFS_CMP1_HI : OFS_CMP2_HI;
      localparam logic [7:0] OFS_LO = (i == 0) ? OFS_CMP1_LO : OFS_CMP2_LO;

      // High byte waits in a hold register until the low byte lands
      always_ff @(posedge CLOCK or negedge RST_B) begin
         if (!RST_B) begin
            cmp_high_hold[i] <= CMP_HI_RESET;
            cmp_value[i]     <= {CMP_HI_RESET, CMP_LO_RESET};
         end else if (WR && ADDR == OFS_HI) begin
            cmp_high_hold[i] <= WDATA;
         end else if (WR && ADDR == OFS_LO) begin
            cmp_value[i] <= {cmp_high_hold[i], WDATA};
         end
      end

      // Shadow follows outside PWM, reloads only at period end in PWM
      always_ff @(posedge CLOCK or negedge RST_B) begin
         if (!RST_B) begin
            cmp_shadow[i] <= {CMP_HI_RESET, CMP_LO_RESET};
         end else if (!pwm_mode || pwm_period) begin
            cmp_shadow[i] <= cmp_value[i];
         end
      end

      assign target[i] = pwm_mode ? cmp_shadow[i] : cmp_value[i];
      // Matches sampled the cycle after each count step
      assign match[i]  = tick_d && (counter == (div2_sel ? target[i]
                                                         : 16'(target[i] + 16'h0001)));
   end

   assign opm_trig       = one_pulse & cap_hit[0];
   assign pwm_period     = pwm_mode & match[1];
   assign counter_reload = cnt_reset_wr | opm_trig | pwm_period;

   // Counter: write reset, pulse/PWM reload, then tick
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         counter <= COUNTER_RESET;
      end else if (counter_reload) begin
         counter <= COUNTER_RESET;
      end else if (tk.tick) begin
         counter <= counter + 16'h0001;
      end
   end

   // Tick and halt history
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         tick_d <= 1'b0;
         halt_d <= 1'b0;
      end else begin
         tick_d <= tk.tick;
         halt_d <= HALT;
      end
   end

   // Capture registers; capture one is disconnected in PWM
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         capture_value_one <= 16'h0000;
         capture_value_two <= 16'h0000;
      end else begin
         if (cap_hit[0] && !pwm_mode) begin
            capture_value_one <= counter;
         end
         if (cap_hit[1]) begin
            capture_value_two <= counter;
         end
      end
   end

   // Flag set sources
   assign flag_set[F_CAP1] = (cap_hit[0] & !pwm_mode) | pwm_period;
   assign flag_set[F_CMP1] = match[0] & !pwm_mode & !one_pulse;
   assign flag_set[F_OVF]  = tk.tick & (counter == COUNTER_TOP);
   assign flag_set[F_CAP2] = cap_hit[1];
   assign flag_set[F_CMP2] = match[1] & !pwm_mode;
   assign flag_clr         = status_seen & low_access;

   // Per-flag two-step clear; a set in the clear cycle wins
   for (genvar k = 0; k < 5; k++) begin : g_flag
      always_ff @(posedge CLOCK or negedge RST_B) begin
         if (!RST_B) begin
            flag[k]        <= 1'b0;
            status_seen[k] <= 1'b0;
         end else begin
            flag[k] <= flag_set[k] | (flag[k] & !flag_clr[k]);
            if (rd_status) begin
               status_seen[k] <= flag[k];
            end else if (flag_clr[k]) begin
               status_seen[k] <= 1'b0;
            end
         end
      end
   end

   // Control and disable registers
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_one      <= CTRL_RESET;
         ctrl_two      <= CTRL_RESET;
         timer_disable <= 1'b0;
      end else begin
         if (wr_ctrl_one) begin
            ctrl_one <= WDATA;
         end
         if (WR && ADDR == OFS_CTRL_TWO) begin
            ctrl_two <= WDATA;
         end
         if (WR && ADDR == OFS_STATUS) begin
            timer_disable <= WDATA[B_DIS];
         end
      end
   end

   // Compare pin one level: pulse start, period start, match, force
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         COMPARE_PIN_ONE <= 1'b0;
      end else if (opm_trig || pwm_period) begin
         COMPARE_PIN_ONE <= ctrl_one[B_LVL2];
      end else if (match[0]) begin
         COMPARE_PIN_ONE <= ctrl_one[B_LVL1];
      end else if (wr_ctrl_one && WDATA[B_FORCE1] && !one_pulse && !pwm_mode) begin
         COMPARE_PIN_ONE <= WDATA[B_LVL1];
      end
   end

   // Compare pin two level: match outside pulse/PWM, or force
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         COMPARE_PIN_TWO <= 1'b0;
      end else if (match[1] && !one_pulse && !pwm_mode) begin
         COMPARE_PIN_TWO <= ctrl_one[B_LVL2];
      end else if (wr_ctrl_one && WDATA[B_FORCE2] && !one_pulse && !pwm_mode) begin
         COMPARE_PIN_TWO <= WDATA[B_LVL2];
      end
   end

   // Pin routing only; compare logic above runs regardless
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         COMPARE_PIN_ONE_OE <= 1'b0;
         COMPARE_PIN_TWO_OE <= 1'b0;
      end else begin
         COMPARE_PIN_ONE_OE <= ctrl_two[B_PIN1_EN] & !timer_disable;
         COMPARE_PIN_TWO_OE <= ctrl_two[B_PIN2_EN] & !timer_disable;
      end
   end

   // Shared request; held off in halt so it never ends halt
   assign irq_cause = ((flag[F_CAP1] | flag[F_CAP2]) & ctrl_one[B_CAP_IE])
                    | ((flag[F_CMP1] | flag[F_CMP2]) & ctrl_one[B_CMP_IE])
                    | (flag[F_OVF] & ctrl_one[B_OVF_IE]);

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= irq_cause & !GLOBAL_MASK & !HALT;
      end
   end

   // Read data mux
   always_comb begin
      if (ADDR == OFS_CTRL_TWO) begin
         next_rdata = ctrl_two;
      end else if (ADDR == OFS_CTRL_ONE) begin
         next_rdata = ctrl_one;
      end else if (ADDR == OFS_STATUS) begin
         next_rdata = {flag, timer_disable, 2'b00};
      end else if (ADDR == OFS_CAP1_HI) begin
         next_rdata = capture_value_one[15:8];
      end else if (ADDR == OFS_CAP1_LO) begin
         next_rdata = capture_value_one[7:0];
      end else if (ADDR == OFS_CMP1_HI) begin
         next_rdata = cmp_high_hold[0];
      end else if (ADDR == OFS_CMP1_LO) begin
         next_rdata = cmp_value[0][7:0];
      end else if (ADDR == OFS_CNT_HI || ADDR == OFS_ALT_HI) begin
         next_rdata = counter[15:8];
      end else if (ADDR == OFS_CNT_LO || ADDR == OFS_ALT_LO) begin
         next_rdata = counter[7:0];
      end else if (ADDR == OFS_CAP2_HI) begin
         next_rdata = capture_value_two[15:8];
      end else if (ADDR == OFS_CAP2_LO) begin
         next_rdata = capture_value_two[7:0];
      end else if (ADDR == OFS_CMP2_HI) begin
         next_rdata = cmp_high_hold[1];
      end else if (ADDR == OFS_CMP2_LO) begin
         next_rdata = cmp_value[1][7:0];
      end else begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= RD ? next_rdata : 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   freeze_hold_a: assert property (
      (tk.freeze && !tick_d && !counter_reload) |=> $stable(counter))
      else $error("counter moved while frozen");

   overflow_set_a: assert property (
      (flag_set[F_OVF] && !counter_reload) |=> (flag[F_OVF] && counter == 16'h0000))
      else $error("wrap did not set overflow");

   alt_keep_a: assert property (
      (flag[F_OVF] && (RD || WR) && ADDR == OFS_ALT_LO) |=> flag[F_OVF])
      else $error("alternate counter access cleared overflow");

   irq_mask_a: assert property (
      (GLOBAL_MASK || HALT) |=> !IRQ)
      else $error("request raised while masked or halted");

   irq_ovf_a: assert property (
      (flag[F_OVF] && ctrl_one[B_OVF_IE] && !GLOBAL_MASK && !HALT) [*2] |-> IRQ)
      else $error("enabled overflow gave no request");

   cmp1_pin_a: assert property (
      (match[0] && !pwm_mode && !one_pulse) |=> COMPARE_PIN_ONE == $past(ctrl_one[B_LVL1]))
      else $error("compare one level not driven");

   pwm_reload_a: assert property (
      pwm_period |=> (counter == COUNTER_RESET && flag[F_CAP1] && COMPARE_PIN_ONE == $past(ctrl_one[B_LVL2])))
      else $error("PWM period end wrong");

   cmp2_clear_a: assert property (
      (rd_status && flag[F_CMP2]) ##1 (low_access[F_CMP2] && !flag_set[F_CMP2]) |=> !flag[F_CMP2])
      else $error("compare two flag not cleared");

   disable_pins_a: assert property (
      timer_disable |=> (!COMPARE_PIN_ONE_OE && !COMPARE_PIN_TWO_OE))
      else $error("pins driven while disabled");

   capture_copy_a: assert property (
      (cap_hit[0] && !pwm_mode) |=> (capture_value_one == $past(counter) && flag[F_CAP1]))
      else $error("capture one not taken");

   opm_start_a: assert property (
      opm_trig |=> (counter == COUNTER_RESET && COMPARE_PIN_ONE == $past(ctrl_one[B_LVL2])))
      else $error("single pulse did not start");

   pwm_cycle_c: cover property (pwm_period ##[1:300] match[0]);
   opm_pulse_c: cover property (opm_trig ##[1:300] match[0]);
   overflow_c: cover property (flag_set[F_OVF]);
   halt_capture_c: cover property (wake && cap_hit[0]);
endmodule

// >>> cct_timer_tb_top.sv
// Self-checking bench for the capture/compare timer.
// Assumes the pin model above drives capture and external clock pins.
`timescale 1ns/1ps
module cct_timer_tb_top;
   import cct_pkg::*;
   logic       CLOCK = 0, RST_B = 0, WR = 0, RD = 0, HALT = 0, GLOBAL_MASK = 0, run = 0;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, v;
   logic [1:0] lvl = 2'h0;
   logic       COMPARE_PIN_ONE, COMPARE_PIN_ONE_OE, COMPARE_PIN_TWO, COMPARE_PIN_TWO_OE, IRQ;
   logic       CAPTURE_PIN_ONE, CAPTURE_PIN_TWO, EXT_CLOCK_PIN;
   logic [15:0] cv;
   int         n_mismatch = 0, checked = 0;
   // Clock
   always #5 CLOCK = ~CLOCK;
   cct_pins pins (.clk(CLOCK), .lvl(lvl), .run(run), .cap_one(CAPTURE_PIN_ONE),
      .cap_two(CAPTURE_PIN_TWO), .ext_clk(EXT_CLOCK_PIN));
   cct_timer uut (.CLOCK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .CAPTURE_PIN_ONE,
      .CAPTURE_PIN_TWO, .EXT_CLOCK_PIN, .HALT, .GLOBAL_MASK, .COMPARE_PIN_ONE,
      .COMPARE_PIN_ONE_OE, .COMPARE_PIN_TWO, .COMPARE_PIN_TWO_OE, .IRQ);
   // Counter value after n ticks from reload
   function automatic logic [15:0] after(input int n);
      return COUNTER_RESET + 16'(n);
   endfunction
   task automatic chk(input string n, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr8(input logic [7:0] a, d);
      @(posedge CLOCK) begin WR <= 1; ADDR <= a; WDATA <= d; end
      @(posedge CLOCK) WR <= 0;
   endtask
   task automatic rdc(input string n, input logic [7:0] a, e);
      @(posedge CLOCK) begin RD <= 1; ADDR <= a; end
      @(posedge CLOCK) RD <= 0;
      #1 chk(n, RDATA, e);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      #100us n_mismatch++;
      end_of_test;
   end
   // Main sequence
   initial begin
      void'($urandom(81922));
      repeat (20) @(posedge CLOCK);
      RST_B <= 1;
      rdc("status", OFS_STATUS, 8'h00);
      rdc("ctrl1", OFS_CTRL_ONE, CTRL_RESET);
      wr8(OFS_STATUS, 8'h04);
      rdc("ctrl2", OFS_CTRL_TWO, CTRL_RESET);
      rdc("cmp1_hi", OFS_CMP1_HI, CMP_HI_RESET);
      rdc("cmp1_lo", OFS_CMP1_LO, CMP_LO_RESET);
      rdc("unmapped", 8'h40, 8'h00);
      repeat (4) begin
         v = 8'($urandom);
         wr8(OFS_CTRL_ONE, v);
         rdc("ctrl1", OFS_CTRL_ONE, v);
         wr8(OFS_CMP1_HI, ~v);
         rdc("cmp1_hi", OFS_CMP1_HI, ~v);
         wr8(OFS_CMP1_LO, v);
         rdc("cmp1_lo", OFS_CMP1_LO, v);
      end
      // External clock, rising edges, wrap to zero
      wr8(OFS_CTRL_TWO, 8'h0D);
      wr8(OFS_CNT_LO, 8'h00);
      wr8(OFS_STATUS, 8'h00);
      @(posedge CLOCK) run <= 1;
      repeat (8) @(posedge CLOCK);
      run <= 0;
      repeat (3) @(posedge CLOCK);
      cv = after(4);
      rdc("cnt_hi", OFS_CNT_HI, cv[15:8]);
      rdc("cnt_lo", OFS_CNT_LO, cv[7:0]);
      rdc("status", OFS_STATUS, 8'h20);
      rdc("alt_lo", OFS_ALT_LO, cv[7:0]);
      rdc("status", OFS_STATUS, 8'h20);
      rdc("cnt_lo", OFS_CNT_LO, cv[7:0]);
      rdc("status", OFS_STATUS, 8'h00);
      // Capture while frozen; rising on pin two must not capture
      wr8(OFS_STATUS, 8'h04);
      wr8(OFS_CNT_LO, 8'h00);
      wr8(OFS_CTRL_ONE, 8'h82);
      @(posedge CLOCK) lvl <= 2'h3;
      repeat (4) @(posedge CLOCK);
      rdc("status", OFS_STATUS, 8'h84);
      chk("irq", {7'h0, IRQ}, 8'h01);
      @(posedge CLOCK) GLOBAL_MASK <= 1;
      repeat (3) @(posedge CLOCK);
      chk("irq", {7'h0, IRQ}, 8'h00);
      GLOBAL_MASK <= 0;
      rdc("cap1_hi", OFS_CAP1_HI, COUNTER_RESET[15:8]);
      rdc("cap1_lo", OFS_CAP1_LO, COUNTER_RESET[7:0]);
      rdc("status", OFS_STATUS, 8'h04);
      chk("irq", {7'h0, IRQ}, 8'h00);
      @(posedge CLOCK) lvl <= 2'h1;
      repeat (4) @(posedge CLOCK);
      rdc("status", OFS_STATUS, 8'h14);
      // Forced output on pin one
      wr8(OFS_STATUS, 8'h00);
      wr8(OFS_CTRL_TWO, 8'h80);
      wr8(OFS_CTRL_ONE, 8'h09);
      repeat (2) @(posedge CLOCK);
      chk("pin1", {6'h0, COMPARE_PIN_ONE_OE, COMPARE_PIN_ONE}, 8'h03);
      wr8(OFS_CTRL_ONE, 8'h00);
      wr8(OFS_CTRL_ONE, 8'h08);
      repeat (2) @(posedge CLOCK);
      chk("pin1", {6'h0, COMPARE_PIN_ONE_OE, COMPARE_PIN_ONE}, 8'h02);
      wr8(OFS_STATUS, 8'h04);
      repeat (2) @(posedge CLOCK);
      chk("pin1_oe", {7'h0, COMPARE_PIN_ONE_OE}, 8'h00);
      // Compare two match on pin two, divide by 2, counter frozen before compare one
      wr8(OFS_CTRL_ONE, 8'h10);
      wr8(OFS_CTRL_ONE, 8'h04);
      wr8(OFS_CMP1_HI, 8'h80);
      wr8(OFS_CMP1_LO, 8'h00);
      wr8(OFS_CMP2_HI, 8'hFF);
      wr8(OFS_CMP2_LO, 8'hFE);
      wr8(OFS_CTRL_TWO, 8'h44);
      wr8(OFS_CNT_LO, 8'h00);
      wr8(OFS_STATUS, 8'h00);
      repeat (20) @(posedge CLOCK);
      chk("pin2", {6'h0, COMPARE_PIN_TWO_OE, COMPARE_PIN_TWO}, 8'h03);
      wr8(OFS_STATUS, 8'h04);
      rdc("status", OFS_STATUS, 8'h3C);
      rdc("cmp2_lo", OFS_CMP2_LO, 8'hFE);
      rdc("status", OFS_STATUS, 8'h34);
      end_of_test;
   end
endmodule
